// [src/flash_ctl_consts.svh]
// constants for the flash clock divider and options registers
// assumes a 32-bit avalon word per register, 8-bit data in the low lane
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH

// register byte offsets
`define OFS_CLK_DIV 6'h00
`define OFS_OPTIONS 6'h04
`define OFS_CONFIG 6'h08
`define OFS_STATUS 6'h0c
`define OFS_KEY_DATA 6'h10
`define OFS_SECURITY 6'h14

// clock divider register fields
`define DIV_LOADED_BIT 7
`define PRESCALE_BIT 6
`define DIVISOR_HI 5
`define DIVISOR_LO 0
`define CLK_DIV_RESET 8'h00

// options and security register fields
`define KEY_EN_BIT 7
`define NO_REDIRECT_BIT 6
`define SEC_HI 1
`define SEC_LO 0
`define OPT_ZERO_HI 5
`define OPT_ZERO_LO 2
`define SEC_UNSECURED 2'h2
`define SEC_RESET 2'h3
`define SECURED_BIT 0

// configuration and status fields
`define KEY_ACCESS_BIT 7
`define ACC_ERR_BIT 4

// backdoor key
`define KEY_BYTES 4'h8
`define KEY_IDX_W 3

// prescaler reload: divide by eight
`define PRESCALE_LOAD 3'h7

`endif

// [src/flash_ctl_pkg.sv]
// types shared by the flash clock and options logic
// assumes flash_ctl_consts.svh supplies field positions
package flash_ctl_pkg;

	// nonvolatile options byte as stored in flash
	typedef struct packed {
		logic keyEnable;
		logic redirectDisable;
		logic [3:0] unused;
		logic [1:0] securityCode;
	} nv_options_t;

	// source of a flash write, for key acceptance
	typedef struct packed {
		logic fromDebug;
		logic fromSecure;
	} write_source_t;

	// register slave handshake
	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;

endpackage

// [src/tick_divider.sv]
// reloading down-counter that emits a one-cycle enable pulse
// assumes an active-low reset from the parent, asserted at once and released on sys_clk
`timescale 1ns/1ps
module tick_divider #(
	parameter int WIDTH = 6
) (
	input wire logic sys_clk,
	input wire logic rstSync_n,
	input wire logic run,
	input wire logic en,
	input wire logic [WIDTH-1:0] load,
	output logic tick
);

	logic [WIDTH-1:0] count_r;

	// count down on each enable; pulse and reload at zero
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count_r <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			count_r <= load;
			tick <= 1'b0;
		end else if (en) begin
			tick <= (count_r == '0);
			count_r <= (count_r == '0) ? load : count_r - 1'b1;
		end else begin
			tick <= 1'b0;
		end
	end

endmodule // tick_divider

// [src/flash_clk_opt.sv]
// flash clock divider, options, backdoor key and security state
// assumes avalon-mm master on sys_clk; nonvolatile bytes stable at reset
//
// How it works
// - divisor-loaded flag is read-only, reset clear, set by first divider write with byte lane 0 enabled
// - low seven divider bits readable always, writable once after reset
// - program and erase refused until divisor-loaded flag is set
// - prescale bit selects bus clock or bus clock divided by eight
// - divider input is divided by divisor field plus one
// - each timing pulse is one flash clock cycle, whole pulses only
// - nonvolatile options byte copied into options register at reset
// - options bits five to two read zero; writes ignored
// - key enable clear means no key comparison unsecures
// - matching eight ordered key bytes from secure firmware unsecure
// - key writes from the debug path are never accepted
// - redirect disable set turns vector redirection off
// - only security code 1:0 means unsecured
// - while secured, unsecured sources get no memory access
// - security code becomes 1:0 on key match or blank flash
// - registers are eight-bit; key is eight bytes in flash
// - key access bit on, enter key, clear bit to compare
// - program or erase before divider write sets access error
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"
module flash_clk_opt
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire flash_ctl_pkg::write_source_t writeSource,
	input wire flash_ctl_pkg::nv_options_t nvOptions,
	input wire logic [63:0] storedKey,
	input wire logic progEraseReq,
	input wire logic blankCheckPass,
	input wire logic memReqUnsecured,
	output logic progEraseGo,
	output logic flashClkTick,
	output logic secured,
	output logic memAccessBlock,
	output logic vectorRedirectEn
);
	import flash_ctl_pkg::*;

	logic rstMeta_r;
	logic rstSync_n;
	logic optLoaded_r;
	bus_state_t busState_r;
	logic divLoaded_r;
	logic [6:0] divSetting_r;
	nv_options_t options_r;
	logic [1:0] secCode_r;
	logic keyAccess_r;
	logic [63:0] keyEntry_r;
	logic [3:0] keyCount_r;
	logic accErr_r;
	logic accept;
	logic wrLow;
	logic [7:0] wrByte;
	logic wrDiv;
	logic wrCfg;
	logic wrStat;
	logic wrKey;
	logic keyMatch;
	logic preTick;
	logic divTick;
	logic divEn;
	logic [7:0] rdByte;

	// two-stage release; assertion is immediate, release is clocked
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_n <= rstMeta_r;
		end
	end

	// bus access is taken at the edge where waitrequest is seen low
	assign accept = (busState_r == BUS_ACK) && (read || write);
	assign wrLow = accept && write && byteenable[0];
	assign wrByte = writedata[7:0];
	assign wrDiv = wrLow && (address == `OFS_CLK_DIV);
	assign wrCfg = wrLow && (address == `OFS_CONFIG);
	assign wrStat = wrLow && (address == `OFS_STATUS);
	assign wrKey = wrLow && (address == `OFS_KEY_DATA);

	// one wait cycle per access: request seen, then acknowledged
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			busState_r <= BUS_IDLE;
			waitrequest <= 1'b1;
		end else begin
			case (busState_r)
				BUS_IDLE: begin
					if (read || write) begin
						busState_r <= BUS_ACK;
						waitrequest <= 1'b0;
					end
				end
				BUS_ACK: begin
					busState_r <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
				default: begin
					busState_r <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rdByte = 8'h00;
		case (address)
			`OFS_CLK_DIV: rdByte = {divLoaded_r, divSetting_r};
			`OFS_OPTIONS: begin
				rdByte = 8'h00; // bits five to two stay zero
				rdByte[`KEY_EN_BIT] = options_r.keyEnable;
				rdByte[`NO_REDIRECT_BIT] = options_r.redirectDisable;
				rdByte[`SEC_HI:`SEC_LO] = secCode_r;
			end
			`OFS_CONFIG: rdByte[`KEY_ACCESS_BIT] = keyAccess_r;
			`OFS_STATUS: rdByte[`ACC_ERR_BIT] = accErr_r;
			`OFS_SECURITY: rdByte[`SECURED_BIT] = secured;
			default: rdByte = 8'h00;
		endcase
	end

	// read data registered when the request is first seen
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			readdata <= 32'h0000_0000;
		end else if (busState_r == BUS_IDLE && read) begin
			readdata <= {24'h00_0000, rdByte};
		end
	end

	// first write with byte lane 0 after reset locks the divider, data ignored for flag
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			divLoaded_r <= 1'b0;
			divSetting_r <= 7'(`CLK_DIV_RESET);
		end else if (wrDiv && !divLoaded_r) begin
			divLoaded_r <= 1'b1;
			divSetting_r <= wrByte[`PRESCALE_BIT:`DIVISOR_LO];
		end
	end

	// prescaler runs freely once loaded; divisor counts its ticks when the prescale bit is set, else every cycle
	tick_divider #(.WIDTH(3)) prescaler (
		.sys_clk(sys_clk),
		.rstSync_n(rstSync_n),
		.run(divLoaded_r),
		.en(1'b1),
		.load(`PRESCALE_LOAD),
		.tick(preTick)
	);

	assign divEn = divSetting_r[`PRESCALE_BIT] ? preTick : 1'b1;

	tick_divider #(.WIDTH(6)) divisor (
		.sys_clk(sys_clk),
		.rstSync_n(rstSync_n),
		.run(divLoaded_r),
		.en(divEn),
		.load(divSetting_r[`DIVISOR_HI:`DIVISOR_LO]),
		.tick(divTick)
	);

	// a pulse, not a derived clock, so no second domain exists
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			flashClkTick <= 1'b0;
		end else begin
			flashClkTick <= divTick;
		end
	end

	// program and erase gate; refused requests leave a sticky error
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			progEraseGo <= 1'b0;
		end else begin
			progEraseGo <= progEraseReq && divLoaded_r;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			accErr_r <= 1'b0;
		end else if (progEraseReq && !divLoaded_r) begin
			accErr_r <= 1'b1;
		end else if (wrStat && wrByte[`ACC_ERR_BIT]) begin
			accErr_r <= 1'b0;
		end
	end

	// options captured once, in the first cycle after release
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			optLoaded_r <= 1'b0;
			options_r <= '0;
		end else if (!optLoaded_r) begin
			optLoaded_r <= 1'b1;
			options_r <= nvOptions;
		end
	end

	// key access bit; setting it restarts the byte sequence
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			keyAccess_r <= 1'b0;
		end else if (wrCfg) begin
			keyAccess_r <= wrByte[`KEY_ACCESS_BIT];
		end
	end

	// key bytes only from secure firmware, never the debug path
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			keyEntry_r <= 64'h0;
			keyCount_r <= 4'h0;
		end else if (wrCfg && wrByte[`KEY_ACCESS_BIT] && !keyAccess_r) begin
			keyCount_r <= 4'h0;
		end else if (wrKey && keyAccess_r && !writeSource.fromDebug
				&& writeSource.fromSecure && keyCount_r < `KEY_BYTES) begin
			// first byte lands in the top lane
			keyEntry_r <= {keyEntry_r[55:0], wrByte};
			keyCount_r <= keyCount_r + 4'h1;
		end
	end

	assign keyMatch = options_r.keyEnable
		&& keyCount_r == `KEY_BYTES && keyEntry_r == storedKey;

	// working security code; cleared only until the next reset
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			secCode_r <= `SEC_RESET;
		end else if (!optLoaded_r) begin
			secCode_r <= nvOptions.securityCode;
		end else if (wrCfg && keyAccess_r && !wrByte[`KEY_ACCESS_BIT]
				&& keyMatch) begin
			secCode_r <= `SEC_UNSECURED;
		end else if (blankCheckPass) begin
			secCode_r <= `SEC_UNSECURED;
		end
	end

	// derived status outputs, all registered
	always_ff @(posedge sys_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			secured <= 1'b1;
			memAccessBlock <= 1'b0;
			vectorRedirectEn <= 1'b0;
		end else begin
			secured <= (secCode_r != `SEC_UNSECURED);
			memAccessBlock <= memReqUnsecured
				&& (secCode_r != `SEC_UNSECURED);
			vectorRedirectEn <= !options_r.redirectDisable;
		end
	end

	// checks on the guarded behaviour

	divisor_loaded_flag_first_write_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		wrDiv && !divLoaded_r |=> divLoaded_r)
		else $error("divisor flag not set by first write");

	div_write_once_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		divLoaded_r |=> $stable(divSetting_r) && divLoaded_r)
		else $error("divider setting changed after lock");

	prog_refused_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		progEraseReq && !divLoaded_r |=> !progEraseGo && accErr_r)
		else $error("program allowed before divider written");

	prog_allowed_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		progEraseReq && divLoaded_r |=> progEraseGo)
		else $error("program refused after divider written");

	tick_single_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		flashClkTick && divSetting_r[`PRESCALE_BIT] |=> !flashClkTick)
		else $error("flash tick longer than one cycle");

	tick_off_unloaded_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		!divLoaded_r ##1 !divLoaded_r |-> !flashClkTick)
		else $error("flash tick before divider written");

	opt_readzero_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		address == `OFS_OPTIONS && read && busState_r == BUS_IDLE
		|=> readdata[`OPT_ZERO_HI:`OPT_ZERO_LO] == 4'h0)
		else $error("options reserved bits not zero");

	opt_load_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		$rose(optLoaded_r) |-> options_r == $past(nvOptions)
		&& secCode_r == $past(nvOptions.securityCode))
		else $error("options not loaded at reset");

	no_key_unlock_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		optLoaded_r && !options_r.keyEnable && !blankCheckPass
		&& secCode_r != `SEC_UNSECURED |=> secCode_r != `SEC_UNSECURED)
		else $error("security lifted with key disabled");

	debug_key_reject_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		wrKey && writeSource.fromDebug && !wrCfg |=> $stable(keyCount_r))
		else $error("debug path key byte accepted");

	secure_state_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		optLoaded_r ##1 1'b1
		|-> secured == ($past(secCode_r) != `SEC_UNSECURED))
		else $error("secured output disagrees with code");

	blank_unsecure_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		optLoaded_r && blankCheckPass |=> secCode_r == `SEC_UNSECURED
		##1 !secured)
		else $error("blank check did not unsecure");

	block_access_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		memReqUnsecured && secCode_r != `SEC_UNSECURED |=> memAccessBlock)
		else $error("unsecured access not blocked");

	redirect_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		optLoaded_r |=> vectorRedirectEn == !$past(options_r.redirectDisable))
		else $error("vector redirect wrong");

	bus_answer_a: assert property (
		@(posedge sys_clk) disable iff (!rstSync_n)
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one wait cycle");

endmodule // flash_clk_opt

// [tb/tb.sv]
// self-checking bench for the flash clock divider and options block
// assumes the design's assertions stand inside its own files
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"
module tb;
	import flash_ctl_pkg::*;
	logic sysClk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	write_source_t writeSource = '0;
	nv_options_t nvOptions = '0;
	logic [63:0] storedKey = 64'h0123456789abcdef;
	logic progEraseReq = 1'b0;
	logic blankCheckPass = 1'b0;
	logic memReqUnsecured = 1'b0;
	logic progEraseGo, flashClkTick, secured, memAccessBlock, vectorRedirectEn;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] rd;
	int p;

	flash_clk_opt flash_clk_opt_i (.sys_clk(sysClk), .resetn(resetn),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .writeSource(writeSource),
		.nvOptions(nvOptions), .storedKey(storedKey),
		.progEraseReq(progEraseReq), .blankCheckPass(blankCheckPass),
		.memReqUnsecured(memReqUnsecured), .progEraseGo(progEraseGo),
		.flashClkTick(flashClkTick), .secured(secured),
		.memAccessBlock(memAccessBlock), .vectorRedirectEn(vectorRedirectEn));

	// 50 ns bus clock
	initial begin
		forever #25 sysClk = ~sysClk;
	end

	task finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// request held until waitrequest is sampled low at a rising edge
	task bus_cycle(input logic wr, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sysClk);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge sysClk);
			n++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		// one wait cycle: taken at the second edge of the request
		check("bus wait", n, 2);
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task wr(input logic [5:0] a, input logic [7:0] d);
		bus_cycle(1'b1, a, d, 4'hf, rd);
	endtask

	task rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
		bus_cycle(1'b0, a, 8'h00, 4'hf, rd);
		check(what, rd, {24'h0, exp});
	endtask

	// nonvolatile byte is steady across reset so it is copied in
	task do_reset(input logic [7:0] nv);
		@(posedge sysClk);
		resetn <= 1'b0;
		nvOptions <= nv_options_t'(nv);
		repeat (4) @(posedge sysClk);
		resetn <= 1'b1;
		repeat (6) @(posedge sysClk);
		@(negedge sysClk);
	endtask

	// a one-cycle request pulse, result looked at one cycle later
	task pulse_req(output logic go);
		@(posedge sysClk);
		progEraseReq <= 1'b1;
		@(posedge sysClk);
		progEraseReq <= 1'b0;
		@(negedge sysClk);
		go = progEraseGo;
	endtask

	// cycles between two ticks; tick must drop after one cycle
	task tick_period(output int per);
		int n;
		n = 0;
		@(negedge sysClk);
		while (flashClkTick !== 1'b1 && n < 300) begin
			@(negedge sysClk);
			n++;
		end
		@(negedge sysClk);
		check("tick width", flashClkTick, 1'b0);
		per = 1;
		while (flashClkTick !== 1'b1 && per < 300) begin
			@(negedge sysClk);
			per++;
		end
	endtask

	task enter_key(input logic [1:0] src, input logic [63:0] key);
		@(posedge sysClk);
		writeSource <= write_source_t'(src);
		wr(`OFS_CONFIG, 8'h80);
		for (int i = 0; i < 8; i++) wr(`OFS_KEY_DATA, key[63-8*i -: 8]);
		wr(`OFS_CONFIG, 8'h00);
		repeat (3) @(negedge sysClk);
	endtask

	task t_reset_state();
		do_reset(8'hff);
		check("redirect en", vectorRedirectEn, 1'b0);
		check("secured", secured, 1'b1);
		rdchk("divider", `OFS_CLK_DIV, 8'h00);
		rdchk("options", `OFS_OPTIONS, 8'hc3);
		wr(`OFS_OPTIONS, 8'h00);
		rdchk("options kept", `OFS_OPTIONS, 8'hc3);
		rdchk("unmapped", 6'h3c, 8'h00);
		p = 0;
		repeat (60) begin
			@(negedge sysClk);
			if (flashClkTick === 1'b1) p++;
		end
		check("no tick", p, 0);
	endtask

	task t_divider();
		logic go;
		pulse_req(go);
		check("go unloaded", go, 1'b0);
		rdchk("acc err", `OFS_STATUS, 8'h10);
		wr(`OFS_STATUS, 8'h10);
		rdchk("acc err clr", `OFS_STATUS, 8'h00);
		bus_cycle(1'b1, `OFS_CLK_DIV, 8'h45, 4'he, rd);
		rdchk("lane off", `OFS_CLK_DIV, 8'h00);
		wr(`OFS_CLK_DIV, 8'h03);
		rdchk("first write", `OFS_CLK_DIV, 8'h83);
		wr(`OFS_CLK_DIV, 8'h7f);
		rdchk("second write", `OFS_CLK_DIV, 8'h83);
		tick_period(p);
		check("period div4", p, 4);
	endtask

	task t_prescale();
		logic go;
		do_reset(8'h02);
		check("redirect on", vectorRedirectEn, 1'b1);
		check("unsecured", secured, 1'b0);
		// 20 MHz / 8 / 13 keeps the flash clock near 192 kHz
		wr(`OFS_CLK_DIV, 8'h4c);
		tick_period(p);
		check("period pre8", p, 104);
		@(posedge sysClk);
		memReqUnsecured <= 1'b1;
		repeat (2) @(negedge sysClk);
		check("no block", memAccessBlock, 1'b0);
		@(posedge sysClk);
		memReqUnsecured <= 1'b0;
		pulse_req(go);
		check("go loaded", go, 1'b1);
	endtask

	task t_key();
		do_reset(8'h83);
		@(posedge sysClk);
		memReqUnsecured <= 1'b1;
		repeat (2) @(negedge sysClk);
		check("block", memAccessBlock, 1'b1);
		@(posedge sysClk);
		memReqUnsecured <= 1'b0;
		enter_key(2'b11, storedKey);
		check("debug key", secured, 1'b1);
		enter_key(2'b01, ~storedKey);
		check("wrong key", secured, 1'b1);
		enter_key(2'b01, storedKey);
		check("right key", secured, 1'b0);
		rdchk("sec reg", `OFS_SECURITY, 8'h00);
		rdchk("code 10", `OFS_OPTIONS, 8'h82);
	endtask

	task t_key_off();
		do_reset(8'h03);
		enter_key(2'b01, storedKey);
		check("key off", secured, 1'b1);
		@(posedge sysClk);
		blankCheckPass <= 1'b1;
		@(posedge sysClk);
		blankCheckPass <= 1'b0;
		repeat (3) @(negedge sysClk);
		check("blank", secured, 1'b0);
	endtask

	task t_codes();
		for (int c = 0; c < 4; c++) begin
			do_reset({6'h00, c[1:0]});
			check("code", secured, (c == 2) ? 1'b0 : 1'b1);
		end
	endtask

	// reset held for four cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge sysClk);
		resetn <= 1'b1;
		nvOptions <= nv_options_t'(8'hff);
		t_reset_state();
		t_divider();
		t_prescale();
		t_key();
		t_key_off();
		t_codes();
		finish_test();
	end

	// the scenarios need well under 5000 cycles
	initial begin
		#1000000;
		bad_count++;
		finish_test();
	end
endmodule // tb
